// >>> hdl/cic_pkg.sv
// Constants, register map and types of the core interrupt controller.
// Assumes one core clock; the core and the peripherals share that clock.
package cic_pkg;

  // ----------------------------------------------------------------
  // Register port geometry and register offsets.
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] OFF_OPT = 3'h1;
  localparam logic [ADDR_W-1:0] OFF_PFA = 3'h2;
  localparam logic [ADDR_W-1:0] OFF_PFB = 3'h3;
  localparam logic [ADDR_W-1:0] OFF_PEA = 3'h4;
  localparam logic [ADDR_W-1:0] OFF_PEB = 3'h5;
  localparam logic [ADDR_W-1:0] OFF_STAT = 3'h6;
  localparam logic [ADDR_W-1:0] OFF_MASK = 3'h7;

  // ----------------------------------------------------------------
  // Field positions of irq_control_reg and of the option register.
  // ----------------------------------------------------------------
  localparam int unsigned B_GLOBAL_EN = 7;
  localparam int unsigned B_PERIPH_EN = 6;
  localparam int unsigned B_T0_EN = 5;
  localparam int unsigned B_EXT_EN = 4;
  localparam int unsigned B_PC_EN = 3;
  localparam int unsigned B_T0_FLAG = 2;
  localparam int unsigned B_EXT_FLAG = 1;
  localparam int unsigned B_PC_FLAG = 0;
  localparam int unsigned B_EDGE_SEL = 6;

  // ----------------------------------------------------------------
  // Event status bits seen by the interrupt output.
  // ----------------------------------------------------------------
  localparam int unsigned EV_W = 3;
  localparam int unsigned EV_VEC = 0;
  localparam int unsigned EV_WAKE = 1;
  localparam int unsigned EV_RET = 2;

  // ----------------------------------------------------------------
  // Reset values, vector, counts.
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] OPT_RST = 8'hff;
  localparam logic [EV_W-1:0] EV_RST = 3'h0;
  localparam int unsigned PC_W = 13;
  localparam logic [PC_W-1:0] VECTOR_ADDR = 13'h0004;
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam int unsigned Q_W = 2;
  localparam logic [Q_W-1:0] Q_LAST = 2'h3;
  localparam logic [Q_W-1:0] Q_RST = 2'h0;
  localparam logic [7:0] T0_MAX = 8'hff;
  localparam logic [7:0] T0_ZERO = 8'h00;
  localparam int unsigned PC_PINS = 4;

  typedef enum logic [3:0] {
    CIC_IDLE = 4'b0001,
    CIC_SYNC = 4'b0010,
    CIC_PUSH = 4'b0100,
    CIC_LOAD = 4'b1000
  } cic_vec_e;

endpackage

// >>> hdl/cic_pin_if.sv
// Carrier between the controller and its pin watcher.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface cic_pin_if;
  logic edge_sel;
  logic rd_strobe;
  logic ext_edge;
  logic port_change;
  modport watch (input edge_sel, input rd_strobe, output ext_edge, output port_change);
  modport ctrl (output edge_sel, output rd_strobe, input ext_edge, input port_change);
endinterface

// >>> hdl/cic_pin_watch.sv
// Pin watcher: synchronises the external pin and the change pins, turns the
// pin edge into a one-cycle pulse and raises the change event while the pins differ from the value latched at the last port read.
// Assumes the pins are asynchronous to clk_sys.
`timescale 1ns/1ps
module cic_pin_watch (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ext_irq_pin,
  input wire logic [cic_pkg::PC_PINS-1:0] port_b_a,
  cic_pin_if.watch pw
);
  import cic_pkg::*;

  typedef struct packed {
    logic [PC_PINS:0] sync1;
    logic [PC_PINS:0] sync2;
    logic ext_prev;
    logic [PC_PINS-1:0] latch;
    logic ext_edge;
    logic port_change;
  } cic_watch_s;

  cic_watch_s st_q;
  cic_watch_s st_d;
  logic ext_now;

  // ----------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------
  // Only sync2 is looked at; sync1 feeds nothing but sync2.
  always_comb
  begin
    st_d = st_q;
    st_d.sync1 = {port_b_a, ext_irq_pin};
    st_d.sync2 = st_q.sync1;
    ext_now = st_q.sync2[0];
    st_d.ext_prev = ext_now;
    // Rising edge when the select is set, falling edge otherwise.
    st_d.ext_edge = pw.edge_sel ? (ext_now & ~st_q.ext_prev)
                                : (~ext_now & st_q.ext_prev); // [R11]
    // A read reloads the compare latch; a change that lands on the
    // read is absorbed into the latch and raises no event.
    st_d.port_change = (st_q.sync2[PC_PINS:1] != st_q.latch) & ~pw.rd_strobe; // [R16]
    if (pw.rd_strobe)
    begin
      st_d.latch = st_q.sync2[PC_PINS:1]; // [R15]
    end
  end

  // Register the whole state.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign pw.ext_edge = st_q.ext_edge;
  assign pw.port_change = st_q.port_change;

endmodule

// >>> hdl/cic_core.sv
// Core interrupt controller: request flags, enables, vectoring to the
// fixed vector, return handling and wake-up from sleep.
// Assumes the core, the timer and the peripherals share clk_sys and
// that the core honours core_hold while a vector sequence runs.
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
// Contract
// [R1] Flags latch on their event regardless of any enable.
// [R2] Global enable bit 7 passes unmasked requests; clear blocks all.
// [R3] Global enable plus flag and enable requests vectoring at once.
// [R4] Any reset clears the global enable.
// [R5] Return instruction sets the global enable again.
// [R6] Accepting clears global enable, pushes return address, loads 0004h.
// [R7] Peripheral flags and enables in two register pairs, gated by group bit.
// [R8] Service routine clears serviced flags before re-enabling.
// [R9] Pin event to vector takes three or four instruction cycles.
// [R10] Software clears the global enable in a read-back loop.
// [R11] External pin edge chosen by option bit 6; edge sets flag bit 1.
// [R12] External request masked by enable bit 4.
// [R13] Enabled external request wakes from sleep; global enable decides branch.
// [R14] Timer0 FFh to 00h sets flag bit 2; enable at bit 5.
// [R15] Change on port pins 7..4 sets flag bit 0; enable at bit 3.
// [R16] Change coinciding with a port read may not set the flag.
// [R17] Wake with global enable set vectors to 0004h, else runs in line.
// [R18] Wake-up leaves the causing flags set.
// [R19] Flags stay set until software writes them clear.
module cic_core #(
  parameter int unsigned PA_W = 8,
  parameter int unsigned PB_W = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [cic_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [cic_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [cic_pkg::DATA_W-1:0] reg_rdata,
  input wire logic ext_irq_pin,
  input wire logic [cic_pkg::PC_PINS-1:0] port_b_a,
  input wire logic port_b_rd,
  input wire logic [7:0] timer0_count,
  input wire logic [PA_W-1:0] periph_event_a,
  input wire logic [PB_W-1:0] periph_event_b,
  input wire logic return_from_irq_instr,
  input wire logic core_sleep,
  output logic irq_pending,
  output logic core_hold,
  output logic push_stb,
  output logic pc_load,
  output logic [cic_pkg::PC_W-1:0] pc_vector,
  output logic wake_stb,
  output logic irq
);
  import cic_pkg::*;

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0] ctrl;
    logic [DATA_W-1:0] opt;
    logic [PA_W-1:0] pfa;
    logic [PB_W-1:0] pfb;
    logic [PA_W-1:0] pea;
    logic [PB_W-1:0] peb;
    logic [EV_W-1:0] stat;
    logic [EV_W-1:0] mask;
    logic [7:0] t0_prev;
    logic [Q_W-1:0] qph;
    cic_vec_e vst;
    logic [DATA_W-1:0] rdata;
    logic [PC_W-1:0] vec;
    logic pend;
    logic push;
    logic load;
    logic wake;
    logic irq;
    logic hold;
  } cic_state_s;

  // Every reset clears the control register, global enable included.
  localparam cic_state_s ST_RST = '{
    ctrl: CTRL_RST, // [R4]
    opt: OPT_RST,
    pfa: '0,
    pfb: '0,
    pea: '0,
    peb: '0,
    stat: EV_RST,
    mask: EV_RST,
    t0_prev: T0_ZERO,
    qph: Q_RST,
    vst: CIC_IDLE,
    rdata: '0,
    vec: PC_RST,
    pend: 1'b0,
    push: 1'b0,
    load: 1'b0,
    wake: 1'b0,
    irq: 1'b0,
    hold: 1'b0
  };

  cic_state_s st_q;
  cic_state_s st_d;
  cic_pin_if pw_if ();

  logic boundary;
  logic t0_roll;
  logic periph_src;
  logic core_src;
  logic src;
  logic wake_src;
  logic take;

  // ----------------------------------------------------------------
  // Pin watcher.
  // ----------------------------------------------------------------
  assign pw_if.edge_sel = st_q.opt[B_EDGE_SEL];
  assign pw_if.rd_strobe = port_b_rd;

  cic_pin_watch u_watch (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ext_irq_pin(ext_irq_pin),
    .port_b_a(port_b_a),
    .pw(pw_if.watch)
  );

  // ----------------------------------------------------------------
  // Request sources.
  // ----------------------------------------------------------------
  // The peripheral group bit gates both peripheral register pairs.
  assign periph_src = st_q.ctrl[B_PERIPH_EN] &
                      ((|(st_q.pfa & st_q.pea)) | (|(st_q.pfb & st_q.peb))); // [R7]
  assign core_src = (st_q.ctrl[B_EXT_FLAG] & st_q.ctrl[B_EXT_EN]) | // [R12]
                    (st_q.ctrl[B_T0_FLAG] & st_q.ctrl[B_T0_EN]) | // [R14]
                    (st_q.ctrl[B_PC_FLAG] & st_q.ctrl[B_PC_EN]); // [R15]
  assign src = core_src | periph_src;
  // Timer0 stops in sleep, so it is left out of the wake sources.
  assign wake_src = (st_q.ctrl[B_EXT_FLAG] & st_q.ctrl[B_EXT_EN]) | // [R13]
                    (st_q.ctrl[B_PC_FLAG] & st_q.ctrl[B_PC_EN]) | periph_src;
  assign t0_roll = (st_q.t0_prev == T0_MAX) && (timer0_count == T0_ZERO); // [R14]
  assign boundary = (st_q.qph == Q_LAST);
  // Requests are taken only on an instruction boundary, so one- and
  // two-cycle instructions see the same latency.
  assign take = boundary && (st_q.vst == CIC_IDLE) && !core_sleep &&
                st_q.ctrl[B_GLOBAL_EN] && src; // [R3] [R9] [R17]

  // ----------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.push = 1'b0;
    st_d.load = 1'b0;
    st_d.wake = 1'b0;
    st_d.rdata = '0;
    st_d.t0_prev = timer0_count;
    st_d.qph = st_q.qph + 2'h1;
    // Software writes behave like plain register writes, except the status register, where a one clears its bit.
    if (reg_wr)
    begin
      case (reg_addr)
        OFF_CTRL: st_d.ctrl = reg_wdata; // [R19]
        OFF_OPT: st_d.opt = reg_wdata;
        OFF_PFA: st_d.pfa = reg_wdata[PA_W-1:0]; // [R19]
        OFF_PFB: st_d.pfb = reg_wdata[PB_W-1:0];
        OFF_PEA: st_d.pea = reg_wdata[PA_W-1:0];
        OFF_PEB: st_d.peb = reg_wdata[PB_W-1:0];
        OFF_STAT: st_d.stat = st_q.stat & ~reg_wdata[EV_W-1:0];
        OFF_MASK: st_d.mask = reg_wdata[EV_W-1:0];
        default: st_d.ctrl = st_d.ctrl;
      endcase
    end
    // Events come after the write, so a set wins over a clear.
    if (pw_if.ext_edge)
    begin
      st_d.ctrl[B_EXT_FLAG] = 1'b1; // [R1] [R11]
    end
    if (t0_roll)
    begin
      st_d.ctrl[B_T0_FLAG] = 1'b1; // [R1] [R14]
    end
    if (pw_if.port_change)
    begin
      st_d.ctrl[B_PC_FLAG] = 1'b1; // [R1] [R15]
    end
    st_d.pfa = st_d.pfa | periph_event_a; // [R1] [R7]
    st_d.pfb = st_d.pfb | periph_event_b;
    if (return_from_irq_instr)
    begin
      st_d.ctrl[B_GLOBAL_EN] = 1'b1; // [R5]
      st_d.stat[EV_RET] = 1'b1;
    end
    // Wake-up touches no flag, so the cause stays visible.
    if (core_sleep && wake_src && !st_q.wake)
    begin
      st_d.wake = 1'b1; // [R13] [R18]
      st_d.stat[EV_WAKE] = 1'b1;
    end
    // Vector sequence: accept, one dummy cycle, push, then PC load.
    case (st_q.vst)
      CIC_IDLE:
      begin
        if (take)
        begin
          st_d.ctrl[B_GLOBAL_EN] = 1'b0; // [R6]
          st_d.stat[EV_VEC] = 1'b1;
          st_d.vst = CIC_SYNC;
        end
      end
      CIC_SYNC:
      begin
        if (boundary)
        begin
          st_d.push = 1'b1; // [R6]
          st_d.vst = CIC_PUSH;
        end
      end
      CIC_PUSH:
      begin
        if (boundary)
        begin
          st_d.load = 1'b1; // [R6] [R17]
          st_d.vec = VECTOR_ADDR;
          st_d.vst = CIC_LOAD;
        end
      end
      CIC_LOAD:
      begin
        st_d.vst = CIC_IDLE;
      end
      default:
      begin
        st_d.vst = CIC_IDLE;
      end
    endcase
    // Hold is registered from the next sequence state, so it needs no gate on the pin.
    st_d.hold = (st_d.vst != CIC_IDLE);
    // A clear global enable blocks every request.
    st_d.pend = st_q.ctrl[B_GLOBAL_EN] & src; // [R2] [R3]
    st_d.irq = |(st_d.stat & st_d.mask);
    if (reg_rd)
    begin
      case (reg_addr)
        OFF_CTRL: st_d.rdata = st_q.ctrl;
        OFF_OPT: st_d.rdata = st_q.opt;
        OFF_PFA: st_d.rdata = DATA_W'(st_q.pfa);
        OFF_PFB: st_d.rdata = {{(DATA_W-PB_W){1'b0}}, st_q.pfb};
        OFF_PEA: st_d.rdata = DATA_W'(st_q.pea);
        OFF_PEB: st_d.rdata = {{(DATA_W-PB_W){1'b0}}, st_q.peb};
        OFF_STAT: st_d.rdata = {{(DATA_W-EV_W){1'b0}}, st_q.stat};
        OFF_MASK: st_d.rdata = {{(DATA_W-EV_W){1'b0}}, st_q.mask};
        default: st_d.rdata = '0;
      endcase
    end
  end

  // Register the whole state.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= ST_RST; // [R4]
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register.
  // ----------------------------------------------------------------
  assign reg_rdata = st_q.rdata;
  assign irq_pending = st_q.pend;
  assign core_hold = st_q.hold;
  assign push_stb = st_q.push;
  assign pc_load = st_q.load;
  assign pc_vector = st_q.vec;
  assign wake_stb = st_q.wake;
  assign irq = st_q.irq;

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  flag_latch_a: assert property (pw_if.ext_edge |=> st_q.ctrl[B_EXT_FLAG]) // [R1]
    else $error("External event did not set its flag.");

  enable_block_a: assert property (!st_q.ctrl[B_GLOBAL_EN] |=> !st_q.pend) // [R2]
    else $error("Request pending with global enable clear.");

  vector_req_a: assert property (st_q.ctrl[B_GLOBAL_EN] && src |=> st_q.pend) // [R3]
    else $error("Enabled request did not raise pending.");

  return_enable_a: assert property ( // [R5]
    return_from_irq_instr && !take |=> st_q.ctrl[B_GLOBAL_EN])
    else $error("Return did not set the global enable.");

  accept_seq_a: assert property ( // [R6]
    take |=> !st_q.ctrl[B_GLOBAL_EN] ##4 st_q.push ##4
    (st_q.load && st_q.vec == VECTOR_ADDR))
    else $error("Vector sequence out of step.");

  periph_gate_a: assert property ( // [R7]
    st_q.ctrl[B_GLOBAL_EN] && !st_q.ctrl[B_PERIPH_EN] && !core_src |=> !st_q.pend)
    else $error("Peripheral request passed a clear group enable.");

  latency_a: assert property ( // [R9]
    $rose(st_q.ctrl[B_EXT_FLAG]) && st_q.ctrl[B_EXT_EN] && st_q.ctrl[B_GLOBAL_EN] &&
    st_q.vst == CIC_IDLE && !core_sleep |-> ##[9:12] st_q.load)
    else $error("Pin request not vectored in time.");

  t0_roll_a: assert property (t0_roll |=> st_q.ctrl[B_T0_FLAG]) // [R14]
    else $error("Timer rollover did not set its flag.");

  wake_a: assert property ( // [R13]
    core_sleep && st_q.ctrl[B_EXT_FLAG] && st_q.ctrl[B_EXT_EN] && !st_q.wake
    |=> st_q.wake && st_q.ctrl[B_EXT_FLAG])
    else $error("Enabled pin request did not wake the core.");

  flag_hold_a: assert property ( // [R19]
    st_q.ctrl[B_EXT_FLAG] && !(reg_wr && reg_addr == OFF_CTRL) |=> st_q.ctrl[B_EXT_FLAG])
    else $error("Flag dropped without a write.");

  take_c: cover property (take ##9 st_q.load);
  wake_c: cover property (st_q.wake ##[1:20] st_q.push);
  ret_c: cover property (st_q.load ##[1:200] return_from_irq_instr);

endmodule

// >>> tb/cic_core_model.sv
// Partner model of the processor core sequencer and the timer0 source.
// Assumes it shares clk_sys with the controller; it has no core_hold input and does not obey it.
`timescale 1ns/1ps
module cic_core_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic t0_run,
  input wire logic push_stb,
  input wire logic pc_load,
  input wire logic [cic_pkg::PC_W-1:0] pc_vector,
  output logic [7:0] timer0_count,
  output logic [7:0] push_cnt,
  output logic [cic_pkg::PC_W-1:0] pc_q
);
  import cic_pkg::*;
  // The timer steps only on request, so the bench controls the rollover moment.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer0_count <= 8'hf8;
      push_cnt <= 8'h00;
      pc_q <= PC_RST;
    end
    else
    begin
      if (t0_run)
      begin
        timer0_count <= timer0_count + 8'h01;
      end
      if (push_stb)
      begin
        push_cnt <= push_cnt + 8'h01;
      end
      if (pc_load)
      begin
        pc_q <= pc_vector;
      end
    end
  end
endmodule

// >>> tb/cpu_interrupt_controller_tb_top.sv
// Self-checking bench of the core interrupt controller.
// Assumes one 10 MHz clock and the core model on the vectoring side.
`timescale 1ns/1ps
module cpu_interrupt_controller_tb_top;
  import cic_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 3'h0;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic ext_irq_pin = 1'b0;
  logic [PC_PINS-1:0] port_b_a = 4'h0;
  logic port_b_rd = 1'b0;
  logic [7:0] timer0_count;
  logic [7:0] ev_a = 8'h00;
  logic [0:0] ev_b = 1'b0;
  logic ret = 1'b0;
  logic core_sleep = 1'b0;
  logic t0_run = 1'b0;
  logic irq_pending, core_hold, push_stb, pc_load, wake_stb, irq;
  logic [PC_W-1:0] pc_vector, pc_q;
  logic [7:0] push_cnt;
  int errors = 0;
  int cmp_count = 0;
  int n, i, k;

  cic_core i_cic_core (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_irq_pin(ext_irq_pin), .port_b_a(port_b_a), .port_b_rd(port_b_rd),
    .timer0_count(timer0_count), .periph_event_a(ev_a), .periph_event_b(ev_b),
    .return_from_irq_instr(ret), .core_sleep(core_sleep), .irq_pending(irq_pending),
    .core_hold(core_hold), .push_stb(push_stb), .pc_load(pc_load),
    .pc_vector(pc_vector), .wake_stb(wake_stb), .irq(irq));

  cic_core_model i_cic_core_model (.clk_sys(clk_sys), .rst_n(rst_n), .t0_run(t0_run),
    .push_stb(push_stb), .pc_load(pc_load), .pc_vector(pc_vector),
    .timer0_count(timer0_count), .push_cnt(push_cnt), .pc_q(pc_q));

  // Free-running core clock, 100 ns period.
  always #50 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // Bus, compare and closing tasks.
  // ----------------------------------------------------------------
  // Compare with case equality so that an unknown never passes.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys);
  endtask

  // One-cycle write strobe beside address and data.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just then.
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(16'(reg_rdata), 16'(exp));
  endtask

  // Bounded wait on pc_load or wake_stb; running out ends the run.
  task automatic wait_out(input bit on_wake, input int lim);
    n = 0;
    while (((on_wake ? wake_stb : pc_load) !== 1'b1) && n < lim)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= lim)
    begin
      errors++;
      finish_test();
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hf902fc46));
    tick(16);
    rst_n <= 1'b1;
    rd(OFF_CTRL, CTRL_RST);
    rd(OFF_OPT, OPT_RST);
    // The edge chosen by option bit 6 sets the external flag with every enable clear.
    @(posedge clk_sys);
    ext_irq_pin <= 1'b1;
    tick(6);
    rd(OFF_CTRL, 8'h02);
    wr(OFF_CTRL, 8'h00);
    rd(OFF_CTRL, 8'h00);
    ext_irq_pin <= 1'b0;
    tick(6);
    rd(OFF_CTRL, 8'h00);
    wr(OFF_OPT, 8'hbf);
    ext_irq_pin <= 1'b1;
    tick(6);
    rd(OFF_CTRL, 8'h00);
    ext_irq_pin <= 1'b0;
    tick(6);
    rd(OFF_CTRL, 8'h02);
    wr(OFF_CTRL, 8'h00);
    // Timer0 steps through FFh to 00h and then stops.
    t0_run <= 1'b1;
    tick(10);
    t0_run <= 1'b0;
    rd(OFF_CTRL, 8'h04);
    wr(OFF_CTRL, 8'h00);
    port_b_a <= port_b_a ^ 4'($urandom_range(15, 1));
    tick(6);
    rd(OFF_CTRL, 8'h01);
    // A port read reloads the compare latch; without it the flag comes straight back.
    port_b_rd <= 1'b1;
    @(posedge clk_sys);
    port_b_rd <= 1'b0;
    wr(OFF_CTRL, 8'h00);
    rd(OFF_CTRL, 8'h00);
    // Random peripheral flags land in their own bit and stay until cleared.
    for (i = 0; i < 4; i++)
    begin
      k = $urandom_range(7);
      @(posedge clk_sys);
      ev_a <= 8'h01 << k;
      @(posedge clk_sys);
      ev_a <= 8'h00;
      rd(OFF_PFA, 8'h01 << k);
      wr(OFF_PFA, 8'h00);
    end
    @(posedge clk_sys);
    ev_b <= 1'b1;
    @(posedge clk_sys);
    ev_b <= 1'b0;
    rd(OFF_PFB, 8'h01);
    wr(OFF_PFB, 8'h00);
    // Full vector sequence from a pin edge, with the latency measured.
    wr(OFF_MASK, 8'h01);
    wr(OFF_OPT, 8'hff);
    wr(OFF_CTRL, 8'h90);
    @(posedge clk_sys);
    ext_irq_pin <= 1'b1;
    // The flag lands four edges after the pin and pending one edge later.
    tick(5);
    #1;
    chk(16'(irq_pending), 16'h0001);
    wait_out(1'b0, 40);
    chk(16'(n + 5 > 11 && n + 5 < 17), 16'h0001);
    chk(16'(core_hold), 16'h0001);
    chk(16'(pc_vector), 16'(VECTOR_ADDR));
    // The core model takes the vector on the edge after the load strobe.
    @(posedge clk_sys);
    #1;
    chk(16'(core_hold), 16'h0000);
    chk(16'(pc_q), 16'(VECTOR_ADDR));
    chk(16'(push_cnt), 16'h0001);
    chk(16'(irq_pending), 16'h0000);
    rd(OFF_CTRL, 8'h12);
    chk(16'(irq), 16'h0001);
    wr(OFF_STAT, 8'h01);
    tick(2);
    #1;
    chk(16'(irq), 16'h0000);
    // The routine clears its flag before returning, or it would recur.
    wr(OFF_CTRL, 8'h10);
    @(posedge clk_sys);
    ret <= 1'b1;
    @(posedge clk_sys);
    ret <= 1'b0;
    rd(OFF_CTRL, 8'h90);
    // Clear the global enable and read it back before relying on it.
    wr(OFF_CTRL, 8'h10);
    rd(OFF_CTRL, 8'h10);
    // Sleep with the global enable clear: wake, keep the flag, run in line.
    core_sleep <= 1'b1;
    ext_irq_pin <= 1'b0;
    tick(6);
    ext_irq_pin <= 1'b1;
    wait_out(1'b1, 20);
    chk(16'(irq_pending), 16'h0000);
    rd(OFF_CTRL, 8'h12);
    core_sleep <= 1'b0;
    n = 0;
    repeat (24)
    begin
      @(posedge clk_sys);
      #1;
      n += (pc_load === 1'b1) ? 1 : 0;
    end
    chk(16'(n), 16'h0000);
    rd(OFF_STAT, 8'h06);
    chk(16'(irq), 16'h0000);
    // A second reset in mid-run must clear a set global enable.
    // The pin is brought low first so that no false edge follows the release.
    wr(OFF_CTRL, 8'h80);
    ext_irq_pin <= 1'b0;
    rd(OFF_CTRL, 8'h80);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    rd(OFF_CTRL, CTRL_RST);
    finish_test();
  end
endmodule
